// ==== design/bhbs_consts.svh ====
// Offsets, field positions, reset values and fixed codes of the bridge header.
`ifndef BHBS_CONSTS_SVH
`define BHBS_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define BHBS_OFF_HDR       8'h0c
`define BHBS_OFF_BUS       8'h18
`define BHBS_OFF_IOST      8'h1c
`define BHBS_OFF_IRQ_STAT  8'h40
`define BHBS_OFF_IRQ_MASK  8'h44

// ----------------------------------------------------------------------
// Fixed values and reset values
// ----------------------------------------------------------------------
`define BHBS_HDR_TYPE      8'h01
`define BHBS_LAT_TIMER     8'h00
`define BHBS_IO_32BIT      4'h1
`define BHBS_BUS_RST       8'h00
`define BHBS_IO_RST        4'h0
`define BHBS_IO_BASE_LOW   12'h000
`define BHBS_IO_LIM_LOW    12'hfff
`define BHBS_EVT_RST       6'h00
`define BHBS_EVT_W1C       6'h31

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BHBS_F_HDR_LO      16
`define BHBS_F_PRI_LO      0
`define BHBS_F_SEC_LO      8
`define BHBS_F_SUB_LO      16
`define BHBS_F_LAT_LO      24
`define BHBS_F_IOB_IND     0
`define BHBS_F_IOB_LO      4
`define BHBS_F_IOL_IND     8
`define BHBS_F_IOL_LO      12
`define BHBS_B_PAR         24
`define BHBS_B_CA_SENT     27
`define BHBS_B_CA_RCVD     28
`define BHBS_B_UR_RCVD     29
`define BHBS_B_SERR        30
`define BHBS_B_POISON      31

`endif

// ==== design/bhbs_pkg.sv ====
// Types shared by the bridge header register bank.
package bhbs_pkg;

   typedef logic [7:0] bhbs_byte_type;
   typedef logic [3:0] bhbs_nib_type;
   typedef logic [5:0] bhbs_evt_vec_type;

   // Index of each sticky error event inside the event vectors.
   typedef enum logic [2:0]
   {
      BHBS_EV_PAR,
      BHBS_EV_CA_SENT,
      BHBS_EV_CA_RCVD,
      BHBS_EV_UR_RCVD,
      BHBS_EV_SERR,
      BHBS_EV_POISON
   } bhbs_evt_type;

endpackage

// ==== design/bhbs_regs.sv ====
// Bridge header bus numbers, I/O window and secondary status over APB.
//
// What this block does
// - Header type byte reads constant 01h.
// - Upstream bus number byte, writable, resets zero.
// - Downstream bus number byte, writable, resets zero.
// - Highest bus below byte, writable, resets zero.
// - Downstream latency timer byte always reads zero.
// - I/O base and limit nibbles read 1h.
// - I/O base bits 15:12 writable, low zeros.
// - I/O limit bits 15:12 writable, low ones.
// - Forward I/O inside base..limit window.
// - Capability and timing status bits read zero.
// - Parity flag set only with response enable.
// - Completer abort sent sets bit 27.
// - Completer abort received sets bit 28.
// - Unsupported request received sets bit 29.
// - Error message with error enable sets 30.
// - Poisoned packet received sets bit 31.
//
// Decided for this implementation: the APB register port.
`include "bhbs_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module bhbs_regs
(
   input  wire logic        MCLK,
   input  wire logic        RST,
   input  wire logic        CE,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output var  logic [31:0] PRDATA,
   output var  logic        PREADY,
   output var  logic        PSLVERR,
   input  wire logic        EV_PARITY,
   input  wire logic        EV_CA_SENT,
   input  wire logic        EV_CA_RCVD,
   input  wire logic        EV_UR_RCVD,
   input  wire logic        EV_ERR_MSG,
   input  wire logic        EV_POISONED,
   input  wire logic        PARITY_RESP_EN,
   input  wire logic        SERR_EN,
   input  wire logic        IO_REQ,
   input  wire logic [31:0] IO_ADDR,
   input  wire logic [15:0] IO_BASE_UPPER,
   input  wire logic [15:0] IO_LIMIT_UPPER,
   output var  logic        IO_FWD,
   output var  logic [7:0]  UP_BUS,
   output var  logic [7:0]  DOWN_BUS,
   output var  logic [7:0]  SUB_BUS,
   output var  logic        IRQ
);

   // -------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------
   function automatic logic word_hit(input logic [7:0] a,
                                     input logic [7:0] off);
      word_hit = (a[7:2] == off[7:2]);
   endfunction

   function automatic int ev_pos(input int i);
      case (i)
         0:       ev_pos = `BHBS_B_PAR;
         1:       ev_pos = `BHBS_B_CA_SENT;
         2:       ev_pos = `BHBS_B_CA_RCVD;
         3:       ev_pos = `BHBS_B_UR_RCVD;
         4:       ev_pos = `BHBS_B_SERR;
         default: ev_pos = `BHBS_B_POISON;
      endcase
   endfunction

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   bhbs_pkg::bhbs_byte_type    up_bus_q;
   bhbs_pkg::bhbs_byte_type    down_bus_q;
   bhbs_pkg::bhbs_byte_type    sub_bus_q;
   bhbs_pkg::bhbs_nib_type     io_base_q;
   bhbs_pkg::bhbs_nib_type     io_lim_q;
   bhbs_pkg::bhbs_evt_vec_type sec_stat_q;
   bhbs_pkg::bhbs_evt_vec_type irq_stat_q;
   bhbs_pkg::bhbs_evt_vec_type irq_mask_q;
   bhbs_pkg::bhbs_evt_vec_type ev;
   bhbs_pkg::bhbs_evt_vec_type w1c;
   logic        access;
   logic        wr_done;
   logic        rd_done;
   logic        mapped;
   logic [31:0] rdata_d;
   logic [31:0] io_lo;
   logic [31:0] io_hi;

   // -------------------------------------------------------------------
   // Event qualification
   // -------------------------------------------------------------------
   always_comb
   begin
      ev = `BHBS_EVT_RST;
      ev[bhbs_pkg::BHBS_EV_PAR]     = EV_PARITY & PARITY_RESP_EN;
      ev[bhbs_pkg::BHBS_EV_CA_SENT] = EV_CA_SENT;
      ev[bhbs_pkg::BHBS_EV_CA_RCVD] = EV_CA_RCVD;
      ev[bhbs_pkg::BHBS_EV_UR_RCVD] = EV_UR_RCVD;
      ev[bhbs_pkg::BHBS_EV_SERR]    = EV_ERR_MSG & SERR_EN;
      ev[bhbs_pkg::BHBS_EV_POISON]  = EV_POISONED;
   end

   // -------------------------------------------------------------------
   // APB slave: one wait state, write and read-clear act on the last edge
   // -------------------------------------------------------------------
   assign access  = PSEL & PENABLE & PREADY;
   assign wr_done = access & PWRITE;
   assign rd_done = access & ~PWRITE;

   always_comb
   begin
      w1c = `BHBS_EVT_RST;
      for (int i = 0; i < 6; i++)
         w1c[i] = PWDATA[ev_pos(i)];
      w1c = w1c & `BHBS_EVT_W1C;
   end

   always_comb
   begin
      rdata_d = 32'h0000_0000;
      mapped  = 1'b1;
      if (word_hit(PADDR, `BHBS_OFF_HDR))
         rdata_d[`BHBS_F_HDR_LO +: 8] = `BHBS_HDR_TYPE;
      else if (word_hit(PADDR, `BHBS_OFF_BUS))
      begin
         rdata_d[`BHBS_F_PRI_LO +: 8] = up_bus_q;
         rdata_d[`BHBS_F_SEC_LO +: 8] = down_bus_q;
         rdata_d[`BHBS_F_SUB_LO +: 8] = sub_bus_q;
         rdata_d[`BHBS_F_LAT_LO +: 8] = `BHBS_LAT_TIMER;
      end
      else if (word_hit(PADDR, `BHBS_OFF_IOST))
      begin
         rdata_d[`BHBS_F_IOB_IND +: 4] = `BHBS_IO_32BIT;
         rdata_d[`BHBS_F_IOL_IND +: 4] = `BHBS_IO_32BIT;
         rdata_d[`BHBS_F_IOB_LO +: 4]  = io_base_q;
         rdata_d[`BHBS_F_IOL_LO +: 4]  = io_lim_q;
         // Bits 16 to 23, 25 and 26 stay zero.
         for (int i = 0; i < 6; i++)
            rdata_d[ev_pos(i)] = sec_stat_q[i];
      end
      else if (word_hit(PADDR, `BHBS_OFF_IRQ_STAT))
      begin
         for (int i = 0; i < 6; i++)
            rdata_d[ev_pos(i)] = irq_stat_q[i];
      end
      else if (word_hit(PADDR, `BHBS_OFF_IRQ_MASK))
      begin
         for (int i = 0; i < 6; i++)
            rdata_d[ev_pos(i)] = irq_mask_q[i];
      end
      else
         mapped = 1'b0;
   end

   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         PREADY  <= 1'b0;
         PRDATA  <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end
      else if (CE)
      begin
         PREADY  <= PSEL & PENABLE & ~PREADY;
         PRDATA  <= (PSEL & ~PWRITE) ? rdata_d : 32'h0000_0000;
         PSLVERR <= PSEL & PENABLE & ~PREADY & ~mapped;
      end
   end

   // -------------------------------------------------------------------
   // Bus numbers and I/O window
   // -------------------------------------------------------------------
   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         up_bus_q   <= `BHBS_BUS_RST;
         down_bus_q <= `BHBS_BUS_RST;
         sub_bus_q  <= `BHBS_BUS_RST;
      end
      else if (CE && wr_done && word_hit(PADDR, `BHBS_OFF_BUS))
      begin
         up_bus_q   <= PWDATA[`BHBS_F_PRI_LO +: 8];
         down_bus_q <= PWDATA[`BHBS_F_SEC_LO +: 8];
         sub_bus_q  <= PWDATA[`BHBS_F_SUB_LO +: 8];
      end
   end

   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         io_base_q <= `BHBS_IO_RST;
         io_lim_q  <= `BHBS_IO_RST;
      end
      else if (CE && wr_done && word_hit(PADDR, `BHBS_OFF_IOST))
      begin
         io_base_q <= PWDATA[`BHBS_F_IOB_LO +: 4];
         io_lim_q  <= PWDATA[`BHBS_F_IOL_LO +: 4];
      end
   end

   // The upper halves live outside this block and are taken as inputs.
   assign io_lo = {IO_BASE_UPPER, io_base_q, `BHBS_IO_BASE_LOW};
   assign io_hi = {IO_LIMIT_UPPER, io_lim_q, `BHBS_IO_LIM_LOW};

   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
         IO_FWD <= 1'b0;
      else if (CE)
         IO_FWD <= IO_REQ & (IO_ADDR >= io_lo) & (IO_ADDR <= io_hi);
   end

   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         UP_BUS   <= `BHBS_BUS_RST;
         DOWN_BUS <= `BHBS_BUS_RST;
         SUB_BUS  <= `BHBS_BUS_RST;
      end
      else if (CE)
      begin
         UP_BUS   <= up_bus_q;
         DOWN_BUS <= down_bus_q;
         SUB_BUS  <= sub_bus_q;
      end
   end

   // -------------------------------------------------------------------
   // Secondary status flags and interrupt
   // -------------------------------------------------------------------
   // A new event wins over a clear in the same cycle.
   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
         sec_stat_q <= `BHBS_EVT_RST;
      else if (CE)
      begin
         if (wr_done && word_hit(PADDR, `BHBS_OFF_IOST))
            sec_stat_q <= (sec_stat_q & ~w1c) | ev;
         else
            sec_stat_q <= sec_stat_q | ev;
      end
   end

   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
         irq_stat_q <= `BHBS_EVT_RST;
      else if (CE)
      begin
         if (rd_done && word_hit(PADDR, `BHBS_OFF_IRQ_STAT))
            irq_stat_q <= ev;
         else
            irq_stat_q <= irq_stat_q | ev;
      end
   end

   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
         irq_mask_q <= `BHBS_EVT_RST;
      else if (CE && wr_done && word_hit(PADDR, `BHBS_OFF_IRQ_MASK))
         for (int i = 0; i < 6; i++)
            irq_mask_q[i] <= PWDATA[ev_pos(i)];
   end

   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
         IRQ <= 1'b0;
      else if (CE)
         IRQ <= |(irq_stat_q & irq_mask_q);
   end

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (RST);

   a_hdr_type_read: assert property (
      PREADY && PSEL && !PWRITE && word_hit(PADDR, `BHBS_OFF_HDR)
      |-> PRDATA == 32'h0001_0000)
      else $error("Header type word reads wrong.");

   a_up_bus_write: assert property (
      CE && wr_done && word_hit(PADDR, `BHBS_OFF_BUS)
      |=> up_bus_q == $past(PWDATA[7:0]))
      else $error("Upstream bus number not written.");

   a_down_bus_write: assert property (
      CE && wr_done && word_hit(PADDR, `BHBS_OFF_BUS)
      |=> ##1 DOWN_BUS == $past(PWDATA[15:8], 2) || !$past(CE))
      else $error("Downstream bus number not written.");

   a_sub_bus_write: assert property (
      CE && wr_done && word_hit(PADDR, `BHBS_OFF_BUS)
      |=> sub_bus_q == $past(PWDATA[23:16]))
      else $error("Highest bus below not written.");

   a_lat_timer_zero: assert property (
      PREADY && PSEL && !PWRITE && word_hit(PADDR, `BHBS_OFF_BUS)
      |-> PRDATA[31:24] == 8'h00)
      else $error("Latency timer not zero.");

   a_io_nibble_read: assert property (
      PREADY && PSEL && !PWRITE && word_hit(PADDR, `BHBS_OFF_IOST)
      |-> PRDATA[3:0] == 4'h1 && PRDATA[11:8] == 4'h1)
      else $error("I/O width nibbles wrong.");

   a_io_window_write: assert property (
      CE && wr_done && word_hit(PADDR, `BHBS_OFF_IOST)
      |=> io_base_q == $past(PWDATA[7:4]) && io_lim_q == $past(PWDATA[15:12]))
      else $error("I/O window not written.");

   a_io_fwd_hit: assert property (
      CE && IO_REQ && IO_ADDR[31:12] <= {IO_LIMIT_UPPER, io_lim_q}
      && IO_ADDR[31:12] >= {IO_BASE_UPPER, io_base_q} |=> IO_FWD)
      else $error("I/O inside window not forwarded.");

   a_io_fwd_miss: assert property (
      CE && IO_REQ && IO_ADDR[31:12] > {IO_LIMIT_UPPER, io_lim_q} |=> !IO_FWD)
      else $error("I/O above limit forwarded.");

   a_status_zeros: assert property (
      PREADY && PSEL && !PWRITE && word_hit(PADDR, `BHBS_OFF_IOST)
      |-> PRDATA[26:25] == 2'b00 && PRDATA[23:16] == 8'h00)
      else $error("Fixed status bits not zero.");

   a_par_gated: assert property (
      CE && !PARITY_RESP_EN && !sec_stat_q[0] |=> !sec_stat_q[0])
      else $error("Parity flag set while disabled.");

   a_ca_sent_set: assert property (
      CE && EV_CA_SENT |=> sec_stat_q[1] && irq_stat_q[1])
      else $error("Abort sent flag not set.");

   a_ca_rcvd_set: assert property (
      CE && EV_CA_RCVD |=> sec_stat_q[2])
      else $error("Abort received flag not set.");

   a_ur_rcvd_set: assert property (
      CE && EV_UR_RCVD |=> sec_stat_q[3])
      else $error("Unsupported request flag not set.");

   a_serr_set: assert property (
      CE && EV_ERR_MSG && SERR_EN |=> sec_stat_q[4])
      else $error("System error flag not set.");

   a_poison_set: assert property (
      CE && EV_POISONED |=> sec_stat_q[5])
      else $error("Poisoned flag not set.");

   a_w1c_clear: assert property (
      CE && wr_done && word_hit(PADDR, `BHBS_OFF_IOST) && PWDATA[31]
      && !EV_POISONED |=> !sec_stat_q[5])
      else $error("Write one did not clear flag.");

   a_ro_kept: assert property (
      CE && sec_stat_q[1] |=> sec_stat_q[1])
      else $error("Read-only flag was cleared.");

endmodule

`default_nettype wire

// ==== tb/bridge_header_bus_io_status_tb.sv ====
// Self-checking bench for the bridge header register bank.
`include "bhbs_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module bridge_header_bus_io_status_tb;
   logic        MCLK;
   logic        RST;
   logic        CE;
   logic        PSEL;
   logic        PENABLE;
   logic        PWRITE;
   logic [7:0]  PADDR;
   logic [31:0] PWDATA;
   logic [31:0] PRDATA;
   logic        PREADY;
   logic        PSLVERR;
   logic [5:0]  ev;
   logic        PARITY_RESP_EN;
   logic        SERR_EN;
   logic        IO_REQ;
   logic [31:0] IO_ADDR;
   logic [15:0] IO_BASE_UPPER;
   logic [15:0] IO_LIMIT_UPPER;
   logic        IO_FWD;
   logic [7:0]  UP_BUS;
   logic [7:0]  DOWN_BUS;
   logic [7:0]  SUB_BUS;
   logic        IRQ;
   logic [31:0] q_data[$];
   logic        q_err[$];
   int          fail_count;
   int          tests_run;
   logic [7:0]  pb;
   logic [7:0]  sb;
   logic [7:0]  hb;
   logic [3:0]  base;
   logic [3:0]  lim;
   logic [15:0] up;

   bhbs_regs dut_u
   (
      .MCLK(MCLK), .RST(RST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .EV_PARITY(ev[0]),
      .EV_CA_SENT(ev[1]), .EV_CA_RCVD(ev[2]), .EV_UR_RCVD(ev[3]),
      .EV_ERR_MSG(ev[4]), .EV_POISONED(ev[5]),
      .PARITY_RESP_EN(PARITY_RESP_EN), .SERR_EN(SERR_EN), .IO_REQ(IO_REQ),
      .IO_ADDR(IO_ADDR), .IO_BASE_UPPER(IO_BASE_UPPER),
      .IO_LIMIT_UPPER(IO_LIMIT_UPPER), .IO_FWD(IO_FWD), .UP_BUS(UP_BUS),
      .DOWN_BUS(DOWN_BUS), .SUB_BUS(SUB_BUS), .IRQ(IRQ)
   );

   initial
   begin
      MCLK = 0;
      forever #10 MCLK = ~MCLK;
   end

   task automatic finish_test;
      begin
         $display("checks %0d mismatches %0d", tests_run, fail_count);
         if (fail_count == 0 && tests_run > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      begin
         tests_run++;
         if (seen !== exp)
         begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask

   // Every answer of the slave is compared here against the oldest note.
   always @(posedge MCLK)
      if (PREADY === 1'b1)
      begin
         if (q_data.size() == 0)
            check(32'h1, 32'h0);
         else
         begin
            check(PRDATA, q_data.pop_front());
            check({31'h0, PSLVERR}, {31'h0, q_err.pop_front()});
         end
      end

   // Entered right after a rising edge; the request is held until PREADY.
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [31:0] er,
                      input logic ee);
      int n;
      begin
         n = 0;
         q_data.push_back(er);
         q_err.push_back(ee);
         PSEL <= 1'b1;
         PWRITE <= wr;
         PADDR <= a;
         PWDATA <= d;
         @(posedge MCLK);
         PENABLE <= 1'b1;
         do
         begin
            @(posedge MCLK);
            n++;
         end
         while (PREADY !== 1'b1 && n < 20);
         if (PREADY !== 1'b1)
         begin
            fail_count++;
            finish_test();
         end
         else
         begin
            PSEL <= 1'b0;
            PENABLE <= 1'b0;
            @(posedge MCLK);
         end
      end
   endtask

   task automatic io(input logic [31:0] a, input logic e);
      begin
         IO_REQ <= 1'b1;
         IO_ADDR <= a;
         @(posedge MCLK);
         IO_REQ <= 1'b0;
         @(posedge MCLK);
         check({31'h0, IO_FWD}, {31'h0, e});
      end
   endtask

   task automatic pulse(input logic [5:0] v);
      begin
         ev <= v;
         @(posedge MCLK);
         ev <= 6'h00;
         @(posedge MCLK);
      end
   endtask

   // Expected word at 0x1c for a set of event flags and the window nibbles.
   function automatic logic [31:0] iost(input logic [5:0] v);
      return {v[5:1], 2'b00, v[0], 8'h00, lim, 4'h1, base, 4'h1};
   endfunction

   initial
   begin
      RST = 1'b1;
      CE = 1'b1;
      PSEL = 1'b0;
      PENABLE = 1'b0;
      PWRITE = 1'b0;
      PADDR = 8'h00;
      PWDATA = 32'h0;
      ev = 6'h00;
      PARITY_RESP_EN = 1'b0;
      SERR_EN = 1'b0;
      IO_REQ = 1'b0;
      IO_ADDR = 32'h0;
      IO_BASE_UPPER = 16'h0;
      IO_LIMIT_UPPER = 16'h0;
      fail_count = 0;
      tests_run = 0;
      base = 4'h0;
      lim = 4'h0;
      void'($urandom(15982));
      repeat (8) @(posedge MCLK);
      RST <= 1'b0;
      @(posedge MCLK);

      apb(0, `BHBS_OFF_HDR, 0, 32'h00010000, 0);
      apb(0, `BHBS_OFF_BUS, 0, 32'h0, 0);
      apb(0, `BHBS_OFF_IOST, 0, 32'h00000101, 0);
      apb(0, `BHBS_OFF_IRQ_MASK, 0, 32'h0, 0);
      check({UP_BUS, DOWN_BUS, SUB_BUS, 7'h0, IRQ}, 32'h0);
      $display("reset values test done");

      // The top byte is written with ones to show it stays read-only.
      repeat (4)
      begin
         pb = 8'($urandom);
         sb = 8'($urandom);
         hb = 8'($urandom);
         apb(1, `BHBS_OFF_BUS, {8'hff, hb, sb, pb}, 0, 0);
         apb(0, `BHBS_OFF_BUS, 0, {8'h00, hb, sb, pb}, 0);
         check({8'h0, SUB_BUS, DOWN_BUS, UP_BUS}, {8'h0, hb, sb, pb});
      end
      $display("bus number test done");

      base = 4'(1 + $urandom % 7);
      lim = 4'(base + $urandom % 7);
      up = 16'($urandom % 32768);
      IO_BASE_UPPER <= up;
      IO_LIMIT_UPPER <= up;
      apb(1, `BHBS_OFF_IOST, {16'h0, lim, 4'hf, base, 4'hf}, 0, 0);
      apb(0, `BHBS_OFF_IOST, 0, iost(6'h00), 0);
      io({up, base, 12'h000}, 1'b1);
      io({up, base, 12'h000} - 32'h1, 1'b0);
      io({up, lim, 12'hfff}, 1'b1);
      io({up, lim, 12'hfff} + 32'h1, 1'b0);
      io({up + 16'h1, base, 12'h800}, 1'b0);
      $display("io window test done");

      pulse(6'h11);
      apb(0, `BHBS_OFF_IOST, 0, iost(6'h00), 0);
      PARITY_RESP_EN <= 1'b1;
      SERR_EN <= 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         pulse(6'(1 << i));
         apb(0, `BHBS_OFF_IOST, 0, iost(6'((2 << i) - 1)), 0);
      end
      apb(1, `BHBS_OFF_IOST, {16'h0, lim, 4'h0, base, 4'h0}, 0, 0);
      apb(0, `BHBS_OFF_IOST, 0, iost(6'h3f), 0);
      apb(1, `BHBS_OFF_IOST, {16'hffff, lim, 4'hf, base, 4'hf}, 0, 0);
      apb(0, `BHBS_OFF_IOST, 0, iost(6'h0e), 0);
      $display("status flag test done");

      check({31'h0, IRQ}, 32'h0);
      apb(1, `BHBS_OFF_IRQ_MASK, 32'hf9000000, 0, 0);
      apb(0, `BHBS_OFF_IRQ_MASK, 0, 32'hf9000000, 0);
      check({31'h0, IRQ}, 32'h1);
      apb(0, `BHBS_OFF_IRQ_STAT, 0, 32'hf9000000, 0);
      @(posedge MCLK);
      check({31'h0, IRQ}, 32'h0);
      apb(0, `BHBS_OFF_IRQ_STAT, 0, 32'h0, 0);
      $display("interrupt test done");

      apb(0, 8'h20, 0, 32'h0, 1);
      apb(1, 8'h20, 32'hffffffff, 0, 1);
      apb(0, `BHBS_OFF_HDR, 0, 32'h00010000, 0);
      $display("unmapped access test done");

      // A second reset in mid-run must bring the bus numbers, I/O window and status flags back.
      RST <= 1'b1;
      repeat (2) @(posedge MCLK);
      RST <= 1'b0;
      @(posedge MCLK);
      apb(0, `BHBS_OFF_BUS, 0, 32'h0, 0);
      apb(0, `BHBS_OFF_IOST, 0, 32'h00000101, 0);
      check({UP_BUS, DOWN_BUS, SUB_BUS, 7'h0, IRQ}, 32'h0);
      // Events seen while the clock enable is low must be lost.
      CE <= 1'b0;
      pulse(6'h3f);
      CE <= 1'b1;
      apb(0, `BHBS_OFF_IOST, 0, 32'h00000101, 0);
      $display("mid-run reset and enable test done");

      repeat (2) @(posedge MCLK);
      if (q_data.size() != 0)
         fail_count++;
      finish_test();
   end
endmodule

`default_nettype wire
